// [slsw_defs.vh]
// constants for the sequencer loop status and alarm word bank
// assumes it is included once per file that needs the names
`ifndef SLSW_DEFS_VH
`define SLSW_DEFS_VH
// channel offsets from the loop base channel n, and the parameter
`define SLSW_CH_STATUS 3'h4
`define SLSW_CH_ALARM 3'h5
`define SLSW_PARAM_WORD 8'h01
// coil layout: base coil, stride per loop, coils per loop in use
`define SLSW_COIL_BASE 16'h0128
`define SLSW_COIL_STRIDE 16'h0030
`define SLSW_COIL_COUNT 16'h0020
// status word bit positions
`define SLSW_S_HOLD 0
`define SLSW_S_LOCAL 1
`define SLSW_S_RESET 2
`define SLSW_S_TRACK 3
`define SLSW_S_CONSOLE 4
`define SLSW_S_COMPUTER 5
`define SLSW_S_FWD 6
`define SLSW_S_BACK 7
`define SLSW_S_CFGHOLD 9
`define SLSW_S_DONE 10
`define SLSW_S_PB_LO 13
`define SLSW_S_PB_HI 15
// alarm word bit positions
`define SLSW_A_OOS 12
`define SLSW_A_CFGCHG 13
`define SLSW_A_UNACKEV 14
`define SLSW_A_ACTEV 15
// alarm word: three bits per alarm, unacked one above active
`define SLSW_A_STRIDE 3
`define SLSW_A_UNACK 1
// pending command slots: reset, forward, back, then three pushbuttons
`define SLSW_C_RESET 0
`define SLSW_C_FWD 1
`define SLSW_C_BACK 2
`define SLSW_C_PB 3
// whole-word masks
`define SLSW_ONES16 16'hFFFF
`define SLSW_ONE16 16'h0001
// mask of host-writable stored bits in the alarm word
`define SLSW_A_RW_MASK 16'h5DB6
// reset values
`define SLSW_ZERO16 16'h0000
`define SLSW_ZERO3 3'h0
`define SLSW_ZERO6 6'h00
`endif

// [slsw_top.v]
// sequencer loop status word and alarm status word bank, with coil access
// assumes scan_tick and all engine inputs are generated on mclk
//
// How it works
// R1 - status word at channel n+4, parameter 1
// R2 - alarm word at channel n+5, parameter 1
// R3 - bit 6 write-one step forward, reads zero
// R4 - bit 7 write-one step backward, reads zero
// R5 - bit 9 shows configuration hold, read-only
// R6 - bits 13-15 show switch state, accept writes
// R7 - pushbutton write acts as press and release
// R8 - sustained pushbutton press toggles switch position
// R9 - momentary pushbutton press closes one scan
// R10 - alarm bits 0,3,6,9 show active, read-only
// R11 - alarm bits 1,4,7,10 unacked, read/write
// R12 - alarm bits 2,5,8,11 enables, read/write
// R13 - alarm bit 12 puts alarms out of service
// R14 - alarm bit 13 configuration changed, read-only
// R15 - alarm bit 14 unacked loop event, read/write
// R16 - alarm bit 15 active loop event, read-only
// R17 - hold, track, done read-only; bit 2 resets
// R18 - status bits 8, 11, 12 read zero
// R19 - each flag also reachable as one coil
// R20 - write-one commands become single-scan pulses
`timescale 1ns/1ns
`include "slsw_defs.vh"
module slsw_top #(
  parameter [15:0] LOOP_NUM = 16'h0001
)(
  // clock and reset
  input wire mclk,
  input wire reset,
  // scan timing
  input wire scan_tick,
  // sequencer engine state
  input wire hold_sequencer_flag,
  input wire track_flag,
  input wire steps_completed_flag,
  input wire configuration_hold_flag,
  // alarm and event state
  input wire [3:0] alarm_active,
  input wire [3:0] alarm_unack_set,
  input wire configuration_changed_flag,
  input wire active_loop_event,
  input wire loop_event_set,
  // pushbutton configuration, 1 = sustained
  input wire [2:0] pb_sustained,
  // word access by channel and parameter
  input wire [2:0] host_channel,
  input wire [7:0] host_param,
  input wire host_wr,
  input wire host_rd,
  input wire [15:0] host_wdata,
  output reg [15:0] host_rdata,
  output reg host_rd_valid,
  output reg host_miss,
  // single coil access
  input wire [15:0] coil_addr,
  input wire coil_wr,
  input wire coil_rd,
  input wire coil_wdata,
  output reg coil_rdata,
  output reg coil_rd_valid,
  output reg coil_miss,
  // commands to the sequencer engine, one scan each
  output reg sequencer_reset_command,
  output reg step_forward_command,
  output reg step_backward_command,
  // switch outputs and stored flags
  output reg [2:0] switch_input_state,
  output reg loop_local_flag,
  output reg console_control_flag,
  output reg computer_control_flag,
  output reg [15:0] alarm_rw_bits
);

////////////////////////////////////////////////////////////////////////////////
// first coil of this loop
localparam [15:0] COIL_FIRST = `SLSW_COIL_BASE + `SLSW_COIL_STRIDE * (LOOP_NUM - `SLSW_ONE16);

// one-hot mask for a bit index
function [15:0] bit_mask;
  input [3:0] idx;
  begin
    bit_mask = `SLSW_ONE16 << idx;
  end
endfunction

// true when a channel and parameter pair names a word
function word_hit;
  input [2:0] ch;
  input [7:0] prm;
  input [2:0] want;
  begin
    word_hit = (ch == want) && (prm == `SLSW_PARAM_WORD);
  end
endfunction

////////////////////////////////////////////////////////////////////////////////
// decode of word and coil accesses
wire st_hit = word_hit(host_channel, host_param, `SLSW_CH_STATUS); // R1
wire al_hit = word_hit(host_channel, host_param, `SLSW_CH_ALARM); // R2
// an address below the first coil wraps; the lower compare refuses it
wire [15:0] coil_off = coil_addr - COIL_FIRST;
wire coil_hit = (coil_addr >= COIL_FIRST) && (coil_off < `SLSW_COIL_COUNT); // R19
wire coil_al = coil_off[4];
wire [15:0] coil_bit = bit_mask(coil_off[3:0]);

// write masks and values for each word, from either access path
reg [15:0] st_mask;
reg [15:0] al_mask;
reg [15:0] wval;
always @*
begin
  st_mask = `SLSW_ZERO16;
  al_mask = `SLSW_ZERO16;
  wval = host_wdata;
  if (host_wr && st_hit)
  begin
    st_mask = `SLSW_ONES16;
  end
  else if (host_wr && al_hit)
  begin
    al_mask = `SLSW_ONES16;
  end
  // a hitting host word write wins, a coil write in that cycle is dropped
  else if (coil_wr && coil_hit && !coil_al)
  begin
    st_mask = coil_bit; // R19
    wval = {16{coil_wdata}};
  end
  else if (coil_wr && coil_hit && coil_al)
  begin
    al_mask = coil_bit; // R19
    wval = {16{coil_wdata}};
  end
end

// write-one command requests: reset, forward, back, three pushbuttons
wire [15:0] st_ones = st_mask & wval;
wire [5:0] cmd_req = {st_ones[`SLSW_S_PB_HI:`SLSW_S_PB_LO], st_ones[`SLSW_S_BACK],
  st_ones[`SLSW_S_FWD], st_ones[`SLSW_S_RESET]}; // R3 R4 R17 R6

////////////////////////////////////////////////////////////////////////////////
// pending commands wait for the next scan, new request wins over the clear
reg [5:0] cmd_pend;
wire [5:0] next_cmd_pend = scan_tick ? cmd_req : (cmd_pend | cmd_req);
always @(posedge mclk)
begin
  if (reset)
  begin
    cmd_pend <= `SLSW_ZERO6;
  end
  else
  begin
    cmd_pend <= next_cmd_pend; // R20
  end
end

// engine commands last exactly one scan, from tick to tick
always @(posedge mclk)
begin
  if (reset)
  begin
    sequencer_reset_command <= 1'b0;
    step_forward_command <= 1'b0;
    step_backward_command <= 1'b0;
  end
  else if (scan_tick)
  begin
    sequencer_reset_command <= cmd_pend[`SLSW_C_RESET]; // R17 R20
    step_forward_command <= cmd_pend[`SLSW_C_FWD]; // R3 R20
    step_backward_command <= cmd_pend[`SLSW_C_BACK]; // R4 R20
  end
end

////////////////////////////////////////////////////////////////////////////////
// pushbutton emulation: press and release handled at the scan tick
reg [2:0] next_switch;
integer k;
always @*
begin
  next_switch = switch_input_state;
  for (k = 0; k < 3; k = k + 1)
  begin
    if (pb_sustained[k])
    begin
      if (cmd_pend[`SLSW_C_PB + k])
      begin
        next_switch[k] = ~switch_input_state[k]; // R8
      end
    end
    else
    begin
      // a momentary switch follows the pending press, so it opens at the next tick
      next_switch[k] = cmd_pend[`SLSW_C_PB + k]; // R9
    end
  end
end

always @(posedge mclk)
begin
  if (reset)
  begin
    switch_input_state <= `SLSW_ZERO3;
  end
  else if (scan_tick)
  begin
    switch_input_state <= next_switch; // R7
  end
end

////////////////////////////////////////////////////////////////////////////////
// stored status flags: local, console, computer
always @(posedge mclk)
begin
  if (reset)
  begin
    loop_local_flag <= 1'b0;
    console_control_flag <= 1'b0;
    computer_control_flag <= 1'b0;
  end
  else
  begin
    if (st_mask[`SLSW_S_LOCAL])
    begin
      loop_local_flag <= wval[`SLSW_S_LOCAL];
    end
    if (st_mask[`SLSW_S_CONSOLE])
    begin
      console_control_flag <= wval[`SLSW_S_CONSOLE];
    end
    if (st_mask[`SLSW_S_COMPUTER])
    begin
      computer_control_flag <= wval[`SLSW_S_COMPUTER];
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// alarm word stored bits; hardware sets win over a host clear
reg [15:0] hw_set;
integer j;
always @*
begin
  hw_set = `SLSW_ZERO16;
  for (j = 0; j < 4; j = j + 1)
  begin
    hw_set[`SLSW_A_STRIDE * j + `SLSW_A_UNACK] = alarm_unack_set[j]; // R11
  end
  hw_set[`SLSW_A_UNACKEV] = loop_event_set; // R15
end

wire [15:0] al_wmask = al_mask & `SLSW_A_RW_MASK; // R10 R14 R16
wire [15:0] next_alarm_rw = ((alarm_rw_bits & ~al_wmask) | (wval & al_wmask)) | hw_set;
always @(posedge mclk)
begin
  if (reset)
  begin
    alarm_rw_bits <= `SLSW_ZERO16;
  end
  else
  begin
    alarm_rw_bits <= next_alarm_rw; // R11 R12 R13 R15
  end
end

////////////////////////////////////////////////////////////////////////////////
// read images of the two words
reg [15:0] st_word;
reg [15:0] al_word;
integer m;
always @*
begin
  st_word = `SLSW_ZERO16; // R18, commands read zero
  st_word[`SLSW_S_HOLD] = hold_sequencer_flag; // R17
  st_word[`SLSW_S_LOCAL] = loop_local_flag;
  st_word[`SLSW_S_TRACK] = track_flag; // R17
  st_word[`SLSW_S_CONSOLE] = console_control_flag;
  st_word[`SLSW_S_COMPUTER] = computer_control_flag;
  st_word[`SLSW_S_CFGHOLD] = configuration_hold_flag; // R5
  st_word[`SLSW_S_DONE] = steps_completed_flag; // R17
  st_word[`SLSW_S_PB_HI:`SLSW_S_PB_LO] = switch_input_state; // R6
  al_word = alarm_rw_bits & `SLSW_A_RW_MASK;
  for (m = 0; m < 4; m = m + 1)
  begin
    al_word[`SLSW_A_STRIDE * m] = alarm_active[m]; // R10
  end
  al_word[`SLSW_A_CFGCHG] = configuration_changed_flag; // R14
  al_word[`SLSW_A_ACTEV] = active_loop_event; // R16
end

////////////////////////////////////////////////////////////////////////////////
// word read port, answer one cycle after the strobe
always @(posedge mclk)
begin
  if (reset)
  begin
    host_rdata <= `SLSW_ZERO16;
    host_rd_valid <= 1'b0;
    host_miss <= 1'b0;
  end
  else
  begin
    host_rd_valid <= host_rd;
    host_miss <= (host_rd || host_wr) && !st_hit && !al_hit;
    if (host_rd && st_hit)
    begin
      host_rdata <= st_word; // R1
    end
    else if (host_rd && al_hit)
    begin
      host_rdata <= al_word; // R2
    end
    else if (host_rd)
    begin
      host_rdata <= `SLSW_ZERO16;
    end
  end
end

// coil read port, answer one cycle after the strobe
always @(posedge mclk)
begin
  if (reset)
  begin
    coil_rdata <= 1'b0;
    coil_rd_valid <= 1'b0;
    coil_miss <= 1'b0;
  end
  else
  begin
    coil_rd_valid <= coil_rd;
    coil_miss <= (coil_rd || coil_wr) && !coil_hit;
    if (coil_rd)
    begin
      coil_rdata <= coil_hit && (|((coil_al ? al_word : st_word) & coil_bit)); // R19
    end
  end
end

endmodule

// [slsw_scan_model.sv]
// scan tick source standing in for the controller scan
// assumes its outputs are sampled on the rising edge of mclk
`timescale 1ns/1ns
module slsw_scan_model #(parameter int P = 4) (
  // clock and reset
  input wire mclk,
  input wire reset,
  // one-cycle scan marker
  output logic scan_tick
);
  int cnt = 0;
  initial scan_tick = 1'b0;
  // one pulse every P cycles, quiet in reset, moved off the sampling edge
  always @(negedge mclk)
  begin
    cnt <= (reset || cnt == P - 1) ? 0 : cnt + 1;
    scan_tick <= !reset && cnt == P - 1;
  end
endmodule

// [slsw_chk_assertions.sv]
// port checker for the loop status and alarm word bank
// assumes it is bound to the bank top and sees only its ports
`timescale 1ns/1ns
module slsw_chk (
  // clock and reset
  input wire mclk,
  input wire reset,
  // engine and alarm levels
  input wire scan_tick,
  input wire hold_sequencer_flag,
  input wire configuration_hold_flag,
  input wire [3:0] alarm_active,
  input wire configuration_changed_flag,
  input wire active_loop_event,
  // word access
  input wire [2:0] host_channel,
  input wire [7:0] host_param,
  input wire host_rd,
  input wire [15:0] host_rdata,
  input wire host_rd_valid,
  // outputs
  input wire step_forward_command,
  input wire [2:0] switch_input_state,
  input wire [15:0] alarm_rw_bits
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // reads of each word
  sequence st_rd;
    host_rd && host_channel == 3'h4 && host_param == 8'h01;
  endsequence
  sequence al_rd;
    host_rd && host_channel == 3'h5 && host_param == 8'h01;
  endsequence
  rd_answer_a: assert property (st_rd |=> host_rd_valid)
    else $error("status read not answered");
  al_answer_a: assert property (al_rd |=> host_rd_valid)
    else $error("alarm read not answered");
  cmd_zero_a: assert property (st_rd |=> host_rdata[7:6] == 2'h0)
    else $error("step bits read nonzero");
  cfg_hold_a: assert property (st_rd |=> host_rdata[9] == $past(configuration_hold_flag))
    else $error("config hold bit wrong");
  hold_view_a: assert property (st_rd |=> host_rdata[0] == $past(hold_sequencer_flag))
    else $error("hold bit wrong");
  spare_zero_a: assert property (st_rd |=> host_rdata[12:11] == 2'h0 && !host_rdata[8])
    else $error("spare bits nonzero");
  pb_view_a: assert property (st_rd |=> host_rdata[15:13] == $past(switch_input_state))
    else $error("switch bits wrong");
  act_view_a: assert property (al_rd |=>
    {host_rdata[9], host_rdata[6], host_rdata[3], host_rdata[0]} == $past(alarm_active))
    else $error("active bits wrong");
  ev_view_a: assert property (al_rd |=> host_rdata[15] == $past(active_loop_event))
    else $error("event bit wrong");
  cc_view_a: assert property (al_rd |=> host_rdata[13] == $past(configuration_changed_flag))
    else $error("changed bit wrong");
  rw_mask_a: assert property ((alarm_rw_bits & 16'hA249) == 16'h0000)
    else $error("stored alarm bits outside mask");
  step_tick_a: assert property ($rose(step_forward_command) |-> $past(scan_tick))
    else $error("step pulse off scan");
endmodule
bind slsw_top slsw_chk u_chk (.mclk(mclk), .reset(reset), .scan_tick(scan_tick),
  .hold_sequencer_flag(hold_sequencer_flag), .configuration_hold_flag(configuration_hold_flag),
  .alarm_active(alarm_active), .configuration_changed_flag(configuration_changed_flag),
  .active_loop_event(active_loop_event), .host_channel(host_channel),
  .host_param(host_param), .host_rd(host_rd), .host_rdata(host_rdata),
  .host_rd_valid(host_rd_valid), .step_forward_command(step_forward_command),
  .switch_input_state(switch_input_state), .alarm_rw_bits(alarm_rw_bits));

// [tb_top.sv]
// self-checking bench for the loop status and alarm word bank
// assumes the scan model paces commands every P cycles
`timescale 1ns/1ns
module tb_top;
  localparam int P = 4;
  logic mclk = 0, reset = 1, scan_tick;
  logic hold_sequencer_flag = 0, track_flag = 0, steps_completed_flag = 0;
  logic configuration_hold_flag = 0, configuration_changed_flag = 0;
  logic active_loop_event = 0, loop_event_set = 0, coil_wdata = 0;
  logic host_wr = 0, host_rd = 0, coil_wr = 0, coil_rd = 0;
  logic [3:0] alarm_active = 4'h0, alarm_unack_set = 4'h0;
  logic [2:0] pb_sustained = 3'h0, host_channel = 3'h4, switch_input_state;
  logic [7:0] host_param = 8'h01;
  logic [15:0] host_wdata = 16'h0000, coil_addr = 16'h0000, host_rdata, alarm_rw_bits;
  logic host_rd_valid, host_miss, coil_rdata, coil_rd_valid, coil_miss, vld, mis;
  logic sequencer_reset_command, step_forward_command, step_backward_command;
  logic loop_local_flag, console_control_flag, computer_control_flag;
  logic [15:0] got;
  int miscompares = 0, check_count = 0;
  wire [5:0] mon = {switch_input_state, step_backward_command, step_forward_command,
    sequencer_reset_command};
  slsw_top uut (.*);
  slsw_scan_model #(.P(P)) scan (.*);
  initial
  begin
    forever #50 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] g, e);
    check_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // one access: c picks coil, w picks write, a is channel or coil number
  task automatic acc(input logic c, w, input logic [15:0] a, d);
    @(negedge mclk);
    host_channel = a[2:0];
    coil_addr = a;
    host_wdata = d;
    coil_wdata = d[0];
    host_wr = w & ~c;
    host_rd = ~w & ~c;
    coil_wr = w & c;
    coil_rd = ~w & c;
    @(negedge mclk);
    {host_wr, host_rd, coil_wr, coil_rd} = 4'h0;
    vld = host_rd_valid | coil_rd_valid;
    mis = host_miss | coil_miss;
    got = c ? {15'h0000, coil_rdata} : host_rdata;
  endtask
  // counts how many cycles a monitored output stays high
  task automatic pulse(input int b, output int n);
    int i;
    n = 0;
    for (i = 0; i < 40 && (n == 0 || mon[b]); i++)
    begin
      @(negedge mclk);
      n += mon[b];
    end
    if (i == 40)
    begin
      miscompares++;
      report_and_stop;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_status;
    {hold_sequencer_flag, track_flag, steps_completed_flag, configuration_hold_flag} = 4'hF;
    acc(0, 1, 16'h0004, 16'h1FFF);
    acc(0, 0, 16'h0004, 16'h0000);
    chk("status word", got, 16'h063B);
    chk("status valid", vld, 1'b1);
    chk("stored", {loop_local_flag, console_control_flag, computer_control_flag}, 3'h7);
    {hold_sequencer_flag, track_flag, steps_completed_flag, configuration_hold_flag} = 4'h0;
    acc(0, 0, 16'h0004, 16'h0000);
    chk("status cleared", got, 16'h0032);
    acc(0, 0, 16'h0003, 16'h0000);
    chk("word miss", {got[14:0], mis}, 16'h0001);
    host_param = 8'h02;
    acc(0, 0, 16'h0004, 16'h0000);
    chk("param miss", mis, 1'b1);
    host_param = 8'h01;
    $display("done status");
  endtask
  task automatic t_alarm;
    alarm_active = 4'hA;
    {configuration_changed_flag, active_loop_event} = 2'h3;
    acc(0, 1, 16'h0005, 16'hFFFF);
    acc(0, 0, 16'h0005, 16'h0000);
    chk("alarm word", got, 16'hFFBE);
    chk("alarm stored", alarm_rw_bits, 16'h5DB6);
    acc(0, 1, 16'h0005, 16'h0000);
    acc(1, 1, 16'd313, 16'h0001);
    acc(0, 0, 16'h0005, 16'h0000);
    chk("alarm cleared", got, 16'hA20A);
    acc(1, 0, 16'd315, 16'h0000);
    chk("coil active", {got[14:0], vld}, 16'h0003);
    hold_sequencer_flag = 1'b1;
    acc(1, 0, 16'd296, 16'h0000);
    chk("coil hold", got, 16'h0001);
    hold_sequencer_flag = 1'b0;
    acc(1, 0, 16'd328, 16'h0000);
    chk("coil miss", mis, 1'b1);
    // host clear and hardware set in one cycle: the set must win
    @(negedge mclk);
    {host_wr, host_channel, host_wdata} = {1'b1, 3'h5, 16'h0000};
    {loop_event_set, alarm_unack_set} = 5'h14;
    @(negedge mclk);
    {host_wr, loop_event_set, alarm_unack_set} = 6'h00;
    chk("set wins", alarm_rw_bits, 16'h4080);
    $display("done alarm");
  endtask
  task automatic t_cmd;
    int k, n;
    for (k = 0; k < 3; k++)
    begin
      acc(0, 1, 16'h0004, 16'h0001 << (k == 0 ? 2 : k + 5));
      pulse(k, n);
      chk("command length", n, P);
    end
    $display("done commands");
  endtask
  task automatic t_pb;
    int n;
    pb_sustained = 3'h1;
    acc(0, 1, 16'h0004, 16'hE000);
    pulse(4, n);
    chk("momentary length", n, P);
    chk("sustained on", switch_input_state, 3'h1);
    acc(0, 1, 16'h0004, 16'h2000);
    repeat (2 * P) @(negedge mclk);
    chk("sustained off", switch_input_state, 3'h0);
    $display("done pushbuttons");
  endtask
  initial
  begin
    repeat (6) @(negedge mclk);
    reset = 0;
    t_status;
    t_alarm;
    t_cmd;
    t_pb;
    report_and_stop;
  end
endmodule
